// File: hdl/cio_params.svh
// Constants of the configurable I/O serial port: offsets, fields, reset values, counts.
// Assumes inclusion by hdl/cio_serial_port.sv and by the bench; definitions only.
`ifndef CIO_PARAMS_SVH
`define CIO_PARAMS_SVH

// ==========================================================
// Frame and pins
`define CIO_FRAME_BITS      5'd16
`define CIO_LAST_BIT        5'd15
`define CIO_PIN_COUNT       8
`define CIO_BUSY_PIN        7

// ==========================================================
// Register byte offsets
`define CIO_OFF_PIN_MODE    8'h00
`define CIO_OFF_CTRL        8'h04
`define CIO_OFF_GPIO_OUT    8'h08
`define CIO_OFF_GPIO_IN     8'h0C
`define CIO_OFF_TX_WORD     8'h10
`define CIO_OFF_RX_WORD     8'h14
`define CIO_OFF_STATUS      8'h18

// ==========================================================
// Fields and reset values
`define CIO_CTRL_REF_BIT    0
`define CIO_CTRL_BUSY_BIT   1
`define CIO_STAT_VALID_BIT  0
`define CIO_STAT_FRAME_BIT  1
`define CIO_RST_PIN_MODE    16'hAAAA
`define CIO_RST_WORD16      16'h0000
`define CIO_RST_BYTE        8'h00
`define CIO_HTRANS_NONSEQ   2'b10

`endif

// File: hdl/cio_pkg.sv
// Types of the configurable I/O serial port.
// Assumes the constants header is compiled alongside.
package cio_pkg;

  // ==========================================================
  // Pin functions
  typedef enum logic [1:0] {
    CIO_DAC,
    CIO_ADC,
    CIO_DIN,
    CIO_DOUT
  } cio_mode_type;

  // ==========================================================
  // Core domain state
  typedef struct packed {
    logic [15:0] pin_mode;
    logic        ref_en;
    logic        busy_en;
    logic [7:0]  gpio_out;
    logic [15:0] tx_word;
    logic [15:0] rx_word;
    logic        rx_valid;
    logic [7:0]  pin_s1;
    logic [7:0]  pin_s2;
    logic [7:0]  gpio_in;
    logic [2:0]  rx_tgl_s;
    logic [1:0]  sync_s;
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_addr;
    logic [31:0] rdata;
  } cio_core_type;

  // ==========================================================
  // Link domain state
  typedef struct packed {
    logic [4:0]  fall_cnt;
    logic [15:0] shift;
  } cio_fall_type;

  typedef struct packed {
    logic [15:0] word;
    logic        tgl;
  } cio_cap_type;

endpackage : cio_pkg

// File: hdl/cio_serial_port.sv
// Configurable I/O serial port: link-side shifter on the serial clock, register file on AHB-Lite.
// Assumes a host that drives the serial clock and frame sync, and a core that gives adc_busy.
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "cio_params.svh"

module cio_serial_port (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        serial_clock,
  input  wire logic        frame_sync_n,
  input  wire logic        serial_in,
  output logic             serial_out,
  input  wire logic [7:0]  configurable_pin_in,
  output logic [7:0]       configurable_pin_out,
  output logic [7:0]       configurable_pin_oe,
  output logic [7:0]       dac_enable,
  output logic [7:0]       adc_enable,
  input  wire logic        adc_busy,
  output logic             ref_enable
);

  // ==========================================================
  // Link domain
  // Frame sync doubles as the link reset: the serial clock may stand still outside frames.
  logic                 frame_rst_n;
  cio_pkg::cio_fall_type fall_q;
  cio_pkg::cio_fall_type fall_d;
  cio_pkg::cio_cap_type  cap_q;
  cio_pkg::cio_cap_type  cap_d;
  logic [4:0]           out_idx_q;
  logic [4:0]           out_idx_d;
  cio_pkg::cio_core_type core_q;
  cio_pkg::cio_core_type core_d;

  assign frame_rst_n = reset_n & ~frame_sync_n;

  always_comb begin
    fall_d = fall_q;
    cap_d  = cap_q;
    if (fall_q.fall_cnt < `CIO_FRAME_BITS) begin
      fall_d.fall_cnt = fall_q.fall_cnt + 5'd1;
      fall_d.shift    = {fall_q.shift[14:0], serial_in};
    end
    if (fall_q.fall_cnt == `CIO_LAST_BIT) begin
      cap_d.word = {fall_q.shift[14:0], serial_in};
      cap_d.tgl  = ~cap_q.tgl;
    end
  end

  always_ff @(negedge serial_clock or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fall_q <= '0;
    end else begin
      fall_q <= fall_d;
    end
  end

  always_ff @(negedge serial_clock or negedge reset_n) begin
    if (!reset_n) begin
      cap_q <= '0;
    end else begin
      cap_q <= cap_d;
    end
  end

  // Rising edge follows the falling-edge count, so an idle-low clock does not skip the MSB
  always_comb begin
    out_idx_d = out_idx_q;
    if (fall_q.fall_cnt > out_idx_q && out_idx_q < `CIO_LAST_BIT) begin
      out_idx_d = fall_q.fall_cnt;
    end
  end

  always_ff @(posedge serial_clock or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_idx_q <= '0;
    end else begin
      out_idx_q <= out_idx_d;
    end
  end

  // Index zero while sync is high puts the MSB out as sync falls
  assign serial_out = core_q.tx_word[4'(`CIO_LAST_BIT - out_idx_q)];

  // ==========================================================
  // Core domain: synchronisers, registers, pins
  logic        write_hit;
  logic        rx_event;
  logic        frame_active;
  logic [31:0] read_mux;
  logic        ap_take;

  assign rx_event     = core_q.rx_tgl_s[1] ^ core_q.rx_tgl_s[2];
  assign frame_active = core_q.sync_s[1];
  assign ap_take      = hsel && hready && (htrans == `CIO_HTRANS_NONSEQ);
  assign write_hit    = core_q.ap_valid && core_q.ap_write;

  always_comb begin
    case (haddr[7:0])
      `CIO_OFF_PIN_MODE: read_mux = {16'h0000, core_q.pin_mode};
      `CIO_OFF_CTRL:     read_mux = {30'h0000_0000, core_q.busy_en, core_q.ref_en};
      `CIO_OFF_GPIO_OUT: read_mux = {24'h00_0000, core_q.gpio_out};
      `CIO_OFF_GPIO_IN:  read_mux = {24'h00_0000, core_q.gpio_in};
      `CIO_OFF_TX_WORD:  read_mux = {16'h0000, core_q.tx_word};
      `CIO_OFF_RX_WORD:  read_mux = {16'h0000, core_q.rx_word};
      `CIO_OFF_STATUS:   read_mux = {30'h0000_0000, frame_active, core_q.rx_valid};
      default:           read_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    core_d          = core_q;
    core_d.pin_s1   = configurable_pin_in;
    core_d.pin_s2   = core_q.pin_s1;
    core_d.gpio_in  = core_q.pin_s2;
    core_d.rx_tgl_s = {core_q.rx_tgl_s[1:0], cap_q.tgl};
    core_d.sync_s   = {core_q.sync_s[0], ~frame_sync_n};
    core_d.ap_valid = ap_take;
    core_d.ap_write = hwrite;
    core_d.ap_addr  = haddr[7:0];
    if (ap_take && !hwrite) begin
      core_d.rdata = read_mux;
    end
    if (write_hit) begin
      case (core_q.ap_addr)
        `CIO_OFF_PIN_MODE: core_d.pin_mode = hwdata[15:0];
        `CIO_OFF_CTRL: begin
          core_d.ref_en  = hwdata[`CIO_CTRL_REF_BIT];
          core_d.busy_en = hwdata[`CIO_CTRL_BUSY_BIT];
        end
        `CIO_OFF_GPIO_OUT: core_d.gpio_out = hwdata[7:0];
        // Word is quasi-static for the link; changing it mid-frame would tear the bit stream
        `CIO_OFF_TX_WORD: begin
          if (!frame_active) begin
            core_d.tx_word = hwdata[15:0];
          end
        end
        `CIO_OFF_STATUS: begin
          if (hwdata[`CIO_STAT_VALID_BIT]) begin
            core_d.rx_valid = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Set after clear so a frame landing on the clear is kept
    if (rx_event) begin
      core_d.rx_word  = cap_q.word;
      core_d.rx_valid = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      core_q          <= '0;
      core_q.pin_mode <= `CIO_RST_PIN_MODE;
    end else begin
      core_q <= core_d;
    end
  end

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = core_q.rdata;
  assign ref_enable = core_q.ref_en;

  for (genvar i = 0; i < `CIO_PIN_COUNT; i++) begin : g_pin
    cio_pkg::cio_mode_type mode;
    logic                  busy_pin;
    assign mode     = cio_pkg::cio_mode_type'(core_q.pin_mode[2*i +: 2]);
    assign busy_pin = (i == `CIO_BUSY_PIN) && core_q.busy_en;
    assign dac_enable[i] = !busy_pin && (mode == cio_pkg::CIO_DAC);
    assign adc_enable[i] = !busy_pin && (mode == cio_pkg::CIO_ADC);
    assign configurable_pin_oe[i]  = busy_pin || (mode == cio_pkg::CIO_DOUT);
    assign configurable_pin_out[i] = busy_pin ? adc_busy : core_q.gpio_out[i];
  end

  // ==========================================================
  // Assertions, core domain
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence rx_word_read_s;
    ap_take && !hwrite && haddr[7:0] == `CIO_OFF_RX_WORD;
  endsequence

  sequence pin_change_s;
    configurable_pin_in[0] != $past(configurable_pin_in[0]);
  endsequence

  bus_always_ready_a: assert property (hreadyout && !hresp)
    else $error("Bus slave stalled or erred");
  rx_readback_a: assert property (rx_word_read_s |=> hrdata[15:0] == $past(core_q.rx_word))
    else $error("RX word readback mismatch");
  tx_refused_a: assert property (write_hit && core_q.ap_addr == `CIO_OFF_TX_WORD && frame_active
                                 |=> core_q.tx_word == $past(core_q.tx_word))
    else $error("TX word changed during a frame");
  rx_set_wins_a: assert property (rx_event |=> core_q.rx_valid && core_q.rx_word == $past(cap_q.word))
    else $error("Received frame lost");
  ref_held_off_a: assert property (!ref_enable && !(write_hit && core_q.ap_addr == `CIO_OFF_CTRL)
                                   |=> !ref_enable)
    else $error("Reference enabled without a write");
  busy_pin_a: assert property (core_q.busy_en |-> configurable_pin_oe[7] && configurable_pin_out[7] == adc_busy
                               && !dac_enable[7] && !adc_enable[7])
    else $error("Busy pin not following conversion");
  dout_pin_a: assert property (core_q.pin_mode[1:0] == 2'b11 |-> configurable_pin_oe[0]
                               && configurable_pin_out[0] == core_q.gpio_out[0])
    else $error("Digital output pin not driven");
  // Two synchroniser stages plus the gpio_in stage: a steady level shows one cycle after the window
  gpio_in_sync_a: assert property (pin_change_s ##1 $stable(configurable_pin_in[0]) [*2]
                                   |=> core_q.gpio_in[0] == configurable_pin_in[0])
    else $error("GPIO input not seen after three cycles");

  // ==========================================================
  // Assertions, register writes
  pin_mode_wr_a: assert property (write_hit && core_q.ap_addr == `CIO_OFF_PIN_MODE
                                  |=> core_q.pin_mode == $past(hwdata[15:0]))
    else $error("Pin mode write lost");

  ctrl_wr_a: assert property (write_hit && core_q.ap_addr == `CIO_OFF_CTRL
                              |=> core_q.ref_en == $past(hwdata[`CIO_CTRL_REF_BIT])
                              && core_q.busy_en == $past(hwdata[`CIO_CTRL_BUSY_BIT]))
    else $error("Control write lost");

  gpio_out_wr_a: assert property (write_hit && core_q.ap_addr == `CIO_OFF_GPIO_OUT
                                  |=> core_q.gpio_out == $past(hwdata[7:0]))
    else $error("GPIO output write lost");

  tx_wr_a: assert property (write_hit && core_q.ap_addr == `CIO_OFF_TX_WORD && !frame_active
                            |=> core_q.tx_word == $past(hwdata[15:0]))
    else $error("TX word write lost between frames");

  // Clear only wins when no frame lands in the same cycle
  rx_clear_a: assert property (write_hit && core_q.ap_addr == `CIO_OFF_STATUS
                               && hwdata[`CIO_STAT_VALID_BIT] && !rx_event
                               |=> !core_q.rx_valid)
    else $error("Receive flag not cleared");

  rx_valid_hold_a: assert property (core_q.rx_valid
                                    && !(write_hit && core_q.ap_addr == `CIO_OFF_STATUS)
                                    |=> core_q.rx_valid)
    else $error("Receive flag dropped without a clear");

  // ==========================================================
  // Assertions, register reads
  rdata_stands_a: assert property (!(ap_take && !hwrite) |=> $stable(hrdata))
    else $error("Read data changed without a read");

  status_read_a: assert property (ap_take && !hwrite && haddr[7:0] == `CIO_OFF_STATUS
                                  |=> hrdata[1:0] == $past({frame_active, core_q.rx_valid}))
    else $error("Status readback mismatch");

  gpio_in_read_a: assert property (ap_take && !hwrite && haddr[7:0] == `CIO_OFF_GPIO_IN
                                   |=> hrdata[7:0] == $past(core_q.gpio_in))
    else $error("GPIO input readback mismatch");

  // ==========================================================
  // Assertions, pin functions
  dac_pin_a: assert property (core_q.pin_mode[1:0] == 2'b00
                              |-> dac_enable[0] && !adc_enable[0] && !configurable_pin_oe[0])
    else $error("Analog output pin misconfigured");

  adc_pin_a: assert property (core_q.pin_mode[1:0] == 2'b01
                              |-> adc_enable[0] && !dac_enable[0] && !configurable_pin_oe[0])
    else $error("Analog input pin misconfigured");

  din_pin_a: assert property (core_q.pin_mode[1:0] == 2'b10
                              |-> !dac_enable[0] && !adc_enable[0] && !configurable_pin_oe[0])
    else $error("Digital input pin driven");

  // Without the busy override pin seven behaves as any other pin
  busy_off_a: assert property (!core_q.busy_en && core_q.pin_mode[15:14] == 2'b11
                               |-> configurable_pin_oe[7]
                               && configurable_pin_out[7] == core_q.gpio_out[7])
    else $error("Pin seven held by busy while disabled");

  // Outside a frame the link index is held at zero, so the MSB waits on the pin
  msb_waiting_a: assert property (frame_sync_n |-> serial_out == core_q.tx_word[15])
    else $error("MSB not presented before the frame");

  // ==========================================================
  // Assertions, link domain
  sequence last_fall_s;
    fall_q.fall_cnt == `CIO_LAST_BIT;
  endsequence

  sequence fall_pending_s;
    out_idx_q < fall_q.fall_cnt && out_idx_q < `CIO_LAST_BIT;
  endsequence

  fall_cap_a: assert property (@(negedge serial_clock) disable iff (!frame_rst_n)
                               fall_q.fall_cnt <= `CIO_FRAME_BITS)
    else $error("More than sixteen bits taken");

  fall_step_a: assert property (@(negedge serial_clock) disable iff (!frame_rst_n)
                                fall_q.fall_cnt < `CIO_FRAME_BITS
                                |=> fall_q.fall_cnt == $past(fall_q.fall_cnt) + 5'd1)
    else $error("Falling edge not counted");

  fall_shift_a: assert property (@(negedge serial_clock) disable iff (!frame_rst_n)
                                 fall_q.fall_cnt < `CIO_FRAME_BITS
                                 |=> fall_q.shift[0] == $past(serial_in))
    else $error("Input bit not captured on the falling edge");

  // Extra edges after the sixteenth must leave the frame untouched
  fall_hold_a: assert property (@(negedge serial_clock) disable iff (!frame_rst_n)
                                fall_q.fall_cnt == `CIO_FRAME_BITS
                                |=> fall_q.fall_cnt == `CIO_FRAME_BITS && $stable(fall_q.shift))
    else $error("Bits taken beyond the frame");

  cap_word_a: assert property (@(negedge serial_clock) disable iff (!frame_rst_n)
                               last_fall_s |=> cap_q.word == $past({fall_q.shift[14:0], serial_in})
                               && cap_q.tgl != $past(cap_q.tgl))
    else $error("Completed frame not handed over");

  out_step_a: assert property (@(posedge serial_clock) disable iff (!frame_rst_n)
                               fall_pending_s |=> out_idx_q == $past(fall_q.fall_cnt))
    else $error("Output bit not shifted on the rising edge");

  out_advance_a: assert property (@(posedge serial_clock) disable iff (!frame_rst_n)
                                  out_idx_q != $past(out_idx_q) |-> out_idx_q <= fall_q.fall_cnt)
    else $error("Output advanced without a falling edge");

endmodule : cio_serial_port

// File: verification/cio_host_model.sv
// Host model: SPI master that opens, clocks and closes frames on the link.
// Assumes the bench calls run() only while no other frame is open.
`timescale 1ns/1ps

module cio_host_model (
  output logic      serial_clock,
  output logic      frame_sync_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  // ==========================================================
  // Frames
  initial begin
    serial_clock = 1'b0;
    frame_sync_n = 1'b1;
    serial_in    = 1'b0;
  end

  // A 64 ns period stays under the readback limit, so it also suits pure writes
  task run(input logic [15:0] d, input int nf, input logic idle, output logic [15:0] got);
    int i;
    got = 16'h0000;
    serial_clock = idle;
    #3.7 frame_sync_n = 1'b0;
    // With a low idle level this first rise precedes any fall and must not advance
    if (!idle) #4 serial_clock = 1'b1;
    for (i = 0; i < nf; i++) begin
      serial_in = (i < 16) ? d[15 - i] : ~serial_in;
      #28;
      if (i < 16) got[15 - i] = serial_out;
      serial_clock = 1'b0;
      #32 serial_clock = 1'b1;
      #4;
    end
    // Sync rises before the clock returns to idle, so that edge falls outside the frame
    #28 frame_sync_n = 1'b1;
    serial_in = ~serial_in;
    #4 serial_clock = idle;
  endtask : run
endmodule : cio_host_model

// File: verification/configurable_io_serial_port_tb_top.sv
// Self-checking bench: AHB-Lite master, host link model and expected values.
// Assumes the design header and package are compiled first.
`timescale 1ns/1ps
`include "cio_params.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module configurable_io_serial_port_tb_top;
  logic        clock, reset_n, hsel, hwrite, hreadyout, hresp, adc_busy;
  logic        serial_clock, frame_sync_n, serial_in, serial_out, ref_enable;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  pin_in, pin_out, pin_oe, dac_en, adc_en, ed, ea, eo, g;
  logic [15:0] pm;
  int          failures, checks_done, k, i, em;
  int          rx_q[$];

  cio_serial_port dut (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .serial_clock(serial_clock), .frame_sync_n(frame_sync_n),
    .serial_in(serial_in), .serial_out(serial_out), .configurable_pin_in(pin_in),
    .configurable_pin_out(pin_out), .configurable_pin_oe(pin_oe), .dac_enable(dac_en),
    .adc_enable(adc_en), .adc_busy(adc_busy), .ref_enable(ref_enable));
  cio_host_model host (.serial_clock(serial_clock), .frame_sync_n(frame_sync_n), .serial_in(serial_in),
    .serial_out(serial_out));

  // ==========================================================
  // Bus tasks
  task tally_and_finish;
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      tally_and_finish;
    end
  endtask : wait_ready

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= `CIO_HTRANS_NONSEQ;
    hwrite <= w;
    wait_ready;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    rdv = hrdata;
    `CHK(hresp, 1'b0)
  endtask : xfer

  task rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(rdv, e)
  endtask : rchk

  // ==========================================================
  // Link frames
  task frame(input logic idle, input int nf);
    logic [15:0] tx, rx, got;
    int          n;
    tx = 16'($urandom);
    rx = 16'($urandom);
    xfer(1'b1, `CIO_OFF_TX_WORD, {16'h0000, tx});
    host.run(rx, nf, idle, got);
    if (nf >= 16) begin
      rx_q.push_back(rx);
      `CHK(got, tx)
      n = 0;
      do begin
        xfer(1'b0, `CIO_OFF_STATUS, 32'h0000_0000);
        n++;
      end while (rdv[0] !== 1'b1 && n < 20);
      `CHK(rdv[0], 1'b1)
      xfer(1'b1, `CIO_OFF_STATUS, 32'h0000_0001);
      rchk(`CIO_OFF_STATUS, 32'h0000_0000);
    end else begin
      repeat (20) @(posedge clock);
      rchk(`CIO_OFF_STATUS, 32'h0000_0000);
    end
    rchk(`CIO_OFF_RX_WORD, {16'h0000, 16'(rx_q[$])});
  endtask : frame

  // ==========================================================
  // Sequence
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    {reset_n, hsel, hwrite, adc_busy, haddr, hwdata, htrans, pin_in} = '0;
    hsize = 3'h2;
    void'($urandom(24714));
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    rchk(`CIO_OFF_PIN_MODE, 32'h0000_AAAA);
    rchk(`CIO_OFF_CTRL, 32'h0000_0000);
    `CHK(ref_enable, 1'b0)
    `CHK(pin_oe, 8'h00)
    for (k = 0; k < 6; k++) begin
      pm = (k < 4) ? {8{k[1:0]}} : 16'($urandom);
      g = 8'($urandom);
      xfer(1'b1, `CIO_OFF_PIN_MODE, {16'h0000, pm});
      xfer(1'b1, `CIO_OFF_GPIO_OUT, {24'h00_0000, g});
      @(posedge clock);
      #1;
      for (i = 0; i < 8; i++) begin
        em = pm[2 * i +: 2];
        ed[i] = (em == 0);
        ea[i] = (em == 1);
        eo[i] = (em == 3);
      end
      `CHK(dac_en, ed)
      `CHK(adc_en, ea)
      `CHK(pin_oe, eo)
      `CHK(pin_out & eo, g & eo)
      rchk(`CIO_OFF_PIN_MODE, {16'h0000, pm});
    end
    g = 8'($urandom);
    pin_in <= g;
    repeat (4) @(posedge clock);
    rchk(`CIO_OFF_GPIO_IN, {24'h00_0000, g});
    xfer(1'b1, `CIO_OFF_CTRL, 32'h0000_0003);
    for (i = 1; i >= 0; i--) begin
      @(posedge clock);
      adc_busy <= i[0];
      @(posedge clock);
      #1;
      `CHK(pin_oe[7], 1'b1)
      `CHK(pin_out[7], i[0])
    end
    `CHK(ref_enable, 1'b1)
    frame(1'b0, 16);
    frame(1'b1, 16);
    frame(1'b0, 12);
    frame(1'b1, 18);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(ref_enable, 1'b0)
    reset_n <= 1'b1;
    rchk(`CIO_OFF_PIN_MODE, 32'h0000_AAAA);
    tally_and_finish;
  end
endmodule : configurable_io_serial_port_tb_top
